// [dv/sadc_front_model.sv]
// sadc_front_model: comparator facing the resistor-string level
// assumes the bench holds the input level steady through a conversion
`timescale 1ns/10ps
`default_nettype none
module sadc_front_model #(
    parameter int settle_ns = 0
) (
    input wire logic hclk,
    input wire logic conv_busy,
    input wire logic [9:0] level,
    input wire logic [9:0] dac_code,
    output logic comp_above
);
    logic wander = 1'b0;
    // ====
    // between conversions the output wanders so a stale sample cannot pass
    always @(posedge hclk) wander <= ~wander;
    assign #(settle_ns) comp_above = conv_busy ? level >= dac_code : wander;
endmodule
`default_nettype wire

// [dv/sadc_top_properties.sv]
// sadc_checker: port-level checks of the converter control block
// assumes bind onto sadc_top with hready fed from hreadyout
`timescale 1ns/10ps
`default_nettype none
module sadc_checker (
    // bus side
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    // front end
    input wire logic [9:0] dac_code,
    input wire logic [2:0] analog_chan_sel,
    input wire logic [7:0] analog_pin_enable,
    input wire logic conv_busy
);
    import sadc_pkg::*;
    logic dph, wr, next_dph, next_wr;
    logic [9:0] wa, next_wa;
    logic [11:0] bcnt, next_bcnt;
    // ====
    // data-phase tracker and busy length counter
    always_comb begin
        next_dph = hready ? hsel & htrans[1] : dph;
        next_wr = hready ? hwrite : wr;
        next_wa = hready ? haddr[11:2] : wa;
        next_bcnt = conv_busy ? bcnt + 12'h001 : 12'h000;
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dph <= 1'b0;
            wr <= 1'b0;
            wa <= 10'h000;
            bcnt <= 12'h000;
        end else begin
            dph <= next_dph;
            wr <= next_wr;
            wa <= next_wa;
            bcnt <= next_bcnt;
        end
    end
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    sequence ctl_wr_s;
        dph && wr && wa == SADC_IDX_CONTROL;
    endsequence
    sequence busy_rd_s;
        dph && !wr && wa == SADC_IDX_CONTROL && $past(conv_busy) && conv_busy;
    endsequence
    bus_okay_a: assert property (hreadyout && !hresp) else $error("bus answer not okay");
    chan_write_a: assert property (
        ctl_wr_s |=> analog_chan_sel == $past(hwdata[6:4])) else $error("channel not taken");
    pin_write_a: assert property (
        dph && wr && wa == SADC_IDX_PIN_EN |=> analog_pin_enable == $past(hwdata[7:0]))
        else $error("pin enable not taken");
    sar_mid_a: assert property (
        $rose(conv_busy) |-> dac_code == 10'h200) else $error("trial value not midpoint");
    busy_status_a: assert property (
        busy_rd_s |-> !hrdata[3] && hrdata[0]) else $error("status wrong while busy");
    busy_min_a: assert property (
        $fell(conv_busy) |-> bcnt >= 12'd98) else $error("conversion too short");
    busy_max_a: assert property (
        conv_busy |-> bcnt <= 12'd1606) else $error("conversion too long");
    idle_hold_a: assert property (
        $fell(conv_busy) |=> !conv_busy [*2]) else $error("restarted by itself");
endmodule
bind sadc_top sadc_checker chk (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata,
    .hready, .hrdata, .hreadyout, .hresp, .dac_code, .analog_chan_sel, .analog_pin_enable,
    .conv_busy);
`default_nettype wire

// [dv/sar_adc_control_tb_top.sv]
// sar_adc_control_tb_top: self-checking bench of the converter control
// assumes sadc_pkg, sadc_top, checker and front model compiled first
`timescale 1ns/10ps
`default_nettype none
module sar_adc_control_tb_top;
    import sadc_pkg::*;
    logic hclk, comp_above, hreadyout, hresp, conv_busy;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [1:0] htrans = 2'b00;
    logic [2:0] hsize = 3'b010;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
    logic [9:0] dac_code, level = 10'h000;
    logic [2:0] analog_chan_sel;
    logic [7:0] analog_pin_enable, pe;
    int bad_count = 0, n_tests = 0, cyc = 0;
    localparam logic [31:0] addr_ctl = 32'(SADC_IDX_CONTROL) << SADC_IDX_SHIFT;
    localparam logic [31:0] addr_res = 32'(SADC_IDX_RESULT) << SADC_IDX_SHIFT;
    localparam logic [31:0] addr_pin = 32'(SADC_IDX_PIN_EN) << SADC_IDX_SHIFT;
    sadc_top dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(hreadyout), .hrdata, .hreadyout, .hresp, .comp_above, .dac_code,
        .analog_chan_sel, .analog_pin_enable, .conv_busy);
    sadc_front_model #(.settle_ns(150)) front (.hclk, .conv_busy, .level, .dac_code,
        .comp_above);
    initial begin
        hclk = 1'b0;
        forever #50 hclk = ~hclk;
    end
    always @(posedge hclk) cyc <= cyc + 1;
    // ====
    // shared tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'b10;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        htrans <= 2'b00;
        hwdata <= d;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask
    function automatic int sar_model(input int lvl);
        int t;
        t = 0;
        for (int b = 9; b >= 0; b--)
            if (lvl >= (t | (1 << b))) t = t | (1 << b);
        return t;
    endfunction
    task automatic tally_and_finish;
        if (bad_count == 0 && n_tests > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        #(100 * 30000);
        bad_count++;
        tally_and_finish;
    end
    initial begin
        int ch, ch2, cs, lv, t0, prev;
        logic [31:0] regs[4] = '{addr_ctl, addr_res, addr_pin, addr_pin + 32'h4};
        prev = 0;
        void'($urandom(7349));
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        foreach (regs[i]) begin
            xfer(1'b0, regs[i], $urandom);
            check(rd, 32'h0);
        end
        pe = 8'($urandom);
        xfer(1'b1, addr_pin, {24'h0, pe});
        xfer(1'b0, addr_pin, 32'h0);
        check(rd, {24'h0, pe});
        check({24'h0, analog_pin_enable}, {24'h0, pe});
        for (int i = 0; i < 8; i++) begin
            cs = i % 4;
            ch = $urandom_range(7);
            ch2 = ch ^ 5;
            lv = (i == 0) ? 0 : (i == 1) ? 1023 : $urandom_range(1023);
            level <= 10'(lv);
            xfer(1'b1, addr_ctl, 32'(ch << 4 | cs << 1 | 1));
            t0 = cyc;
            xfer(1'b0, addr_ctl, 32'h0);
            check(rd, 32'(ch << 4 | cs << 1 | 1));
            check({29'h0, analog_chan_sel}, 32'(ch));
            xfer(1'b1, addr_ctl, 32'(ch2 << 4 | cs << 1 | 1));
            xfer(1'b1, addr_res, 32'h155);
            xfer(1'b0, addr_res, 32'h0);
            check(rd, 32'(prev));
            while (conv_busy === 1'b1) @(posedge hclk);
            check(32'(cyc - t0 >= 100 << cs && cyc - t0 <= (100 << cs) + 6), 32'h1);
            @(posedge hclk);
            xfer(1'b0, addr_ctl, 32'h0);
            check(rd, 32'(ch2 << 4 | 8 | cs << 1));
            prev = sar_model(lv);
            xfer(1'b0, addr_res, 32'h0);
            check(rd, 32'(prev));
        end
        tally_and_finish;
    end
endmodule
`default_nettype wire

// [rtl/sadc_pkg.sv]
// sadc_pkg: constants and types for the successive-approximation converter control
// assumes a 32-bit ahb-lite bus with word-aligned registers
package sadc_pkg;
    // ==========================================================
    // register map as word indices; the byte address is the index shifted by two
    localparam logic [9:0] SADC_IDX_CONTROL = 10'h0F3;
    // result and pin enable sit in the next two words after control
    localparam logic [9:0] SADC_IDX_RESULT = 10'h0F4;
    localparam logic [9:0] SADC_IDX_PIN_EN = 10'h0F5;
    localparam int SADC_IDX_SHIFT = 2;
    // ==========================================================
    // control register fields
    localparam int SADC_START_BIT = 0;
    localparam int SADC_CLKSEL_LO = 1;
    localparam int SADC_EOC_BIT = 3;
    localparam int SADC_CHAN_LO = 4;
    localparam logic [7:0] SADC_CONTROL_RESET = 8'h00;
    localparam logic [7:0] SADC_PIN_EN_RESET = 8'h00;
    // ==========================================================
    // conversion timing in conversion-clock cycles
    localparam int SADC_SETUP_CLKS = 10;
    localparam int SADC_BIT_CLKS = 4;
    localparam int SADC_RES_BITS = 10;
    localparam logic [9:0] SADC_SAR_MID = 10'h200;
    // ==========================================================
    typedef enum logic [1:0] {SADC_IDLE, SADC_SETUP, SADC_BITS} sadc_state_t;
endpackage

// [rtl/sadc_top.sv]
// sadc_top: register slave and sequencer of a 10-bit successive-approximation converter
// assumes the comparator output is asynchronous to hclk and is double-registered here
// Summary of operation
// - channel field bits 6..4 selects mux input
// - writing start bit 0 begins conversion
// - sar loads 200h then updates each step
// - one channel, ten-bit result per conversion
// - done sets eoc bit 3, stores result
// - return idle until software starts again
// - each new result overwrites result register
// - ten setup clocks, four clocks per bit
// - bits 2..1 choose conversion clock divider
// - reset clears the start bit
// - channel field writable at any time
// - enabled port-2 pins become analog inputs
`timescale 1ns/10ps
`default_nettype none
module sadc_top (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // analog front end
    input wire logic comp_above,
    output logic [9:0] dac_code,
    output logic [2:0] analog_chan_sel,
    output logic [7:0] analog_pin_enable,
    output logic conv_busy
);
    import sadc_pkg::*;

    // ==========================================================
    // overview
    // register words, by index (byte address is index times four):
    //   control: chan in 6..4, eoc in 3, clock select in 2..1, start in 0
    //   result: ten-bit value in the low bits, read only
    //   pin enable: one bit per port-2 pin, 1 hands the pin to the mux
    // bus timing:
    //   address phase is taken on the edge where hsel, hready and a
    //   non-sequential or sequential transfer are seen together
    //   the slave never inserts wait states, so hreadyout stays high
    //   write data is applied on the edge that closes the data phase
    //   read data is registered on the address edge and stands for
    //   exactly the following data phase, zero at all other times
    // conversion timeline, in conversion-clock ticks:
    //   ticks 0..9 are set-up with the midpoint held on the dac
    //   then ten bit steps of four ticks each, most significant first
    //   each step decides its bit on its last tick and raises the
    //   trial bit of the next step on the same edge
    //   the final step stores the result, sets eoc and drops start
    // hazards and limitations:
    //   the comparator is sampled through two flops, so the dac level
    //   must settle at least two hclk cycles before the bit step ends;
    //   at the fastest clock select a step lasts eight hclk cycles
    //   a start written while busy is dropped, but the channel and clock
    //   select fields still take the new value; the clock select change
    //   stretches or shrinks the running conversion from the next tick
    //   the result register is overwritten at the end of every
    //   conversion, so software must read it before the next conversion ends
    //   there is no sample-and-hold here, the input must stay still
    //   writes to the result word and to unmapped words are dropped
    //   reads of unmapped words return zero
    //   eoc cannot be written; only a new start or reset clears it
    //   only whole-word transfers are expected; hsize is not checked
    //   the divider free-runs while idle and is reset by each start,
    //   so the first set-up tick always lasts a full divider period
    //   the upper address bits are not decoded, so the map repeats

    // ==========================================================
    // bus address phase capture
    logic wr_pend, next_wr_pend;
    logic [9:0] wr_idx, next_wr_idx;
    logic [31:0] next_hrdata;

    // ==========================================================
    // register state
    logic [2:0] chan, next_chan;
    logic [1:0] clksel, next_clksel;
    logic eoc, next_eoc;
    logic start, next_start;
    logic [9:0] result, next_result;
    logic [7:0] pin_en, next_pin_en;

    // ==========================================================
    // sequencer state
    sadc_state_t state, next_state;
    logic [9:0] sar, next_sar;
    logic [3:0] bit_idx, next_bit_idx;
    logic [3:0] step_cnt, next_step_cnt;
    logic [3:0] div_cnt, next_div_cnt;
    logic comp_meta, comp_sync;

    logic addr_ok;
    logic tick;
    logic [3:0] div_max;
    logic start_req;
    logic [9:0] addr_idx;
    logic wr_ctl;
    logic wr_pin;

    assign addr_ok = hsel && hready && htrans[1];
    assign addr_idx = haddr[SADC_IDX_SHIFT +: 10];
    assign wr_ctl = wr_pend && (wr_idx == SADC_IDX_CONTROL);
    assign wr_pin = wr_pend && (wr_idx == SADC_IDX_PIN_EN);

    // divide fxx by 2, 4, 8 or 16 for the conversion clock
    always_comb begin
        case (clksel)
            2'b00: div_max = 4'h1;
            2'b01: div_max = 4'h3;
            2'b10: div_max = 4'h7;
            default: div_max = 4'hF;
        endcase
    end
    assign tick = (div_cnt == div_max);

    // a start bit written while busy is ignored; the running conversion goes on
    assign start_req = wr_ctl && hwdata[SADC_START_BIT] && (state == SADC_IDLE);

    always_comb begin
        next_wr_pend = addr_ok && hwrite;
        next_wr_idx = addr_ok ? addr_idx : wr_idx;
        next_hrdata = 32'h0000_0000;
        if (addr_ok && !hwrite) begin
            case (addr_idx)
                SADC_IDX_CONTROL:
                    next_hrdata = {24'h000000, 1'b0, chan, eoc, clksel, start};
                SADC_IDX_RESULT:
                    next_hrdata = {22'h000000, result};
                SADC_IDX_PIN_EN:
                    next_hrdata = {24'h000000, pin_en};
                default:
                    next_hrdata = 32'h0000_0000;
            endcase
        end
    end

    always_comb begin
        next_chan = chan;
        next_clksel = clksel;
        next_start = start;
        next_eoc = eoc;
        next_result = result;
        next_pin_en = pin_en;
        next_state = state;
        next_sar = sar;
        next_bit_idx = bit_idx;
        next_step_cnt = step_cnt;
        next_div_cnt = tick ? 4'h0 : div_cnt + 4'h1;
        if (wr_ctl) begin
            next_chan = hwdata[SADC_CHAN_LO +: 3];
            next_clksel = hwdata[SADC_CLKSEL_LO +: 2];
        end
        if (wr_pin) begin
            next_pin_en = hwdata[7:0];
        end
        case (state)
            SADC_IDLE: begin
                if (start_req) begin
                    next_start = 1'b1;
                    next_eoc = 1'b0;
                    next_sar = SADC_SAR_MID;
                    next_step_cnt = 4'h0;
                    next_div_cnt = 4'h0;
                    next_state = SADC_SETUP;
                end
            end
            SADC_SETUP: begin
                if (tick) begin
                    if (step_cnt == 4'(SADC_SETUP_CLKS - 1)) begin
                        next_step_cnt = 4'h0;
                        next_bit_idx = 4'(SADC_RES_BITS - 1);
                        next_state = SADC_BITS;
                    end else begin
                        next_step_cnt = step_cnt + 4'h1;
                    end
                end
            end
            SADC_BITS: begin
                if (tick) begin
                    if (step_cnt == 4'(SADC_BIT_CLKS - 1)) begin
                        next_step_cnt = 4'h0;
                        // decide this bit, then try the next one down
                        next_sar[bit_idx] = comp_sync;
                        if (bit_idx == 4'h0) begin
                            next_result = {sar[9:1], comp_sync};
                            next_eoc = 1'b1;
                            next_start = 1'b0;
                            next_state = SADC_IDLE;
                        end else begin
                            next_sar[bit_idx - 4'h1] = 1'b1;
                            next_bit_idx = bit_idx - 4'h1;
                        end
                    end else begin
                        next_step_cnt = step_cnt + 4'h1;
                    end
                end
            end
            default: next_state = SADC_IDLE;
        endcase
    end

    // ==========================================================
    // bus capture registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            wr_idx <= 10'h000;
            hrdata <= 32'h0000_0000;
        end else begin
            wr_pend <= next_wr_pend;
            wr_idx <= next_wr_idx;
            hrdata <= next_hrdata;
        end
    end

    // comparator crosses from the analog side; two flops before use
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            comp_meta <= 1'b0;
            comp_sync <= 1'b0;
        end else begin
            comp_meta <= comp_above;
            comp_sync <= comp_meta;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            chan <= SADC_CONTROL_RESET[6:4];
            clksel <= SADC_CONTROL_RESET[2:1];
            start <= SADC_CONTROL_RESET[0];
            eoc <= SADC_CONTROL_RESET[3];
            result <= 10'h000;
            pin_en <= SADC_PIN_EN_RESET;
            state <= SADC_IDLE;
            sar <= 10'h000;
            bit_idx <= 4'h0;
            step_cnt <= 4'h0;
            div_cnt <= 4'h0;
        end else begin
            chan <= next_chan;
            clksel <= next_clksel;
            start <= next_start;
            eoc <= next_eoc;
            result <= next_result;
            pin_en <= next_pin_en;
            state <= next_state;
            sar <= next_sar;
            bit_idx <= next_bit_idx;
            step_cnt <= next_step_cnt;
            div_cnt <= next_div_cnt;
        end
    end

    // ==========================================================
    // registered outputs
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dac_code <= 10'h000;
            analog_chan_sel <= 3'h0;
            analog_pin_enable <= 8'h00;
            conv_busy <= 1'b0;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            dac_code <= next_sar;
            analog_chan_sel <= next_chan;
            analog_pin_enable <= next_pin_en;
            conv_busy <= (next_state != SADC_IDLE);
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    logic unused_ok;
    assign unused_ok = ^{hsize, haddr[31:12], haddr[1:0]};
endmodule
`default_nettype wire
